// >>> design/irq_ctrl_pkg.sv
// constants shared by the interrupt priority controller
package irq_ctrl_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE_MAIN = 8'h_a8;
    localparam logic [7:0] OFS_PRIORITY_MAIN = 8'h_b8;
    localparam logic [7:0] OFS_EXT_CONFIG = 8'h_e4;
    localparam logic [7:0] OFS_ENABLE_EXT1 = 8'h_e6;
    localparam logic [7:0] OFS_ENABLE_EXT2 = 8'h_e7;
    localparam logic [7:0] OFS_PRIORITY_EXT1 = 8'h_f6;
    localparam logic [7:0] OFS_PRIORITY_EXT2 = 8'h_f7;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h_88;

    // ----------------------------------------------------------------
    // reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h_00;
    localparam logic [7:0] RST_EXT_CONFIG = 8'h_01;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int MAIN_SRC_BITS = 6;
    localparam int EXT2_SRC_BITS = 4;
    localparam int TRIG_A_BIT = 0;
    localparam int PEND_A_BIT = 1;
    localparam int TRIG_B_BIT = 2;
    localparam int PEND_B_BIT = 3;
    localparam int SEL_A_LSB = 0;
    localparam int POL_A_BIT = 3;
    localparam int SEL_B_LSB = 4;
    localparam int POL_B_BIT = 7;
    localparam int SEL_W = 3;

    // ----------------------------------------------------------------
    // sources and timing
    // ----------------------------------------------------------------
    localparam int NUM_SOURCES = 18;
    localparam int SRC_IDX_W = 5;
    localparam int EXT_A_SRC = 0;
    localparam int EXT_B_SRC = 2;
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 5;
    localparam int CNT_W = 3;
    localparam logic [15:0] VEC_BASE = 16'h_0003;
    localparam logic [15:0] VEC_STRIDE = 16'h_0008;

    typedef enum logic {ST_IDLE, ST_CALL} ctrl_state_t;
endpackage : irq_ctrl_pkg

// >>> design/ext_irq_priority_ctrl.sv
// interrupt priority controller with two conditioned external inputs
`timescale 1ns/1ps
module ext_irq_priority_ctrl #(
    parameter logic [15:0] VEC_BASE = irq_ctrl_pkg::VEC_BASE,
    parameter logic [15:0] VEC_STRIDE = irq_ctrl_pkg::VEC_STRIDE
) (
    input wire logic clk_i, // system clock
    input wire logic reset_i, // synchronous reset, active high
    input wire logic [7:0] sfr_addr_i, // register address
    input wire logic sfr_wr_i, // register write strobe
    input wire logic [7:0] sfr_wdata_i, // register write data
    output logic [7:0] sfr_rdata_o, // read data, one cycle after address
    input wire logic [15:0] periph_pending_i, // peripheral pending flags
    input wire logic [7:0] port0_pins_i, // port 0 pin levels
    input wire logic instr_done_i, // instruction completes this cycle
    input wire logic return_from_handler_i, // return instruction completes
    input wire logic cpu_stall_i, // cpu stalled this cycle
    output logic long_subroutine_jump_o, // call to handler in progress
    output logic [15:0] irq_vector_o, // handler address
    output logic [4:0] irq_source_o, // serviced source index
    output logic vector_taken_o // pulse: cpu vectors now
);
    localparam int N = irq_ctrl_pkg::NUM_SOURCES;
    localparam logic [2:0] CALL_LAST = 3'(irq_ctrl_pkg::CALL_CYCLES - 1);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // pick one port-0 pin by a three-bit index
    function automatic logic pin_pick(input logic [7:0] pins, input logic [2:0] sel);
        pin_pick = pins[sel];
    endfunction : pin_pick

    // lowest set bit index of a request vector
    function automatic logic [4:0] lowest_idx(input logic [N-1:0] v);
        logic [4:0] r;
        r = 5'h_00;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        lowest_idx = r;
    endfunction : lowest_idx

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] en_main_reg, en_ext1_reg, en_ext2_reg;
    logic [7:0] pri_main_reg, pri_ext1_reg, pri_ext2_reg;
    logic [7:0] ext_cfg_reg;
    logic trig_a_reg, trig_b_reg;
    logic edge_a_reg, edge_b_reg;
    logic [7:0] pin_s1_reg, pin_s2_reg;
    logic act_a_prev_reg, act_b_prev_reg;
    logic in_hi_reg, in_lo_reg;
    logic hold_reg;
    irq_ctrl_pkg::ctrl_state_t state_reg;
    logic [2:0] cnt_reg;
    logic [4:0] src_reg;
    logic src_hi_reg;

    // write decode
    wire wr_en_main = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_MAIN);
    wire wr_en_ext1 = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_EXT1);
    wire wr_en_ext2 = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_EXT2);
    wire wr_pri_main = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_MAIN);
    wire wr_pri_ext1 = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_EXT1);
    wire wr_pri_ext2 = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_EXT2);
    wire wr_cfg = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_EXT_CONFIG);
    wire wr_timer_ctrl_reg = sfr_wr_i && (sfr_addr_i == irq_ctrl_pkg::OFS_TIMER_CTRL);

    // ----------------------------------------------------------------
    // external inputs
    // ----------------------------------------------------------------
    // two-flop synchroniser on all port-0 pins, read-only taps
    always_ff @(posedge clk_i) begin
        pin_s1_reg <= port0_pins_i;
        pin_s2_reg <= pin_s1_reg;
    end

    wire [2:0] sel_a = ext_cfg_reg[irq_ctrl_pkg::SEL_A_LSB +: irq_ctrl_pkg::SEL_W];
    wire [2:0] sel_b = ext_cfg_reg[irq_ctrl_pkg::SEL_B_LSB +: irq_ctrl_pkg::SEL_W];
    wire pol_a = ext_cfg_reg[irq_ctrl_pkg::POL_A_BIT];
    wire pol_b = ext_cfg_reg[irq_ctrl_pkg::POL_B_BIT];
    // active level after polarity
    wire ext_a_active = pin_pick(pin_s2_reg, sel_a) ~^ pol_a;
    wire ext_b_active = pin_pick(pin_s2_reg, sel_b) ~^ pol_b;
    wire ext_a_rise = ext_a_active && !act_a_prev_reg;
    wire ext_b_rise = ext_b_active && !act_b_prev_reg;

    // pending flags: edge latch or live level
    wire ext_a_pending = trig_a_reg ? edge_a_reg : ext_a_active;
    wire ext_b_pending = trig_b_reg ? edge_b_reg : ext_b_active;

    // vector taken for each external source
    wire take_a = vector_taken_o && (src_reg == 5'(irq_ctrl_pkg::EXT_A_SRC));
    wire take_b = vector_taken_o && (src_reg == 5'(irq_ctrl_pkg::EXT_B_SRC));
    wire sw_set_a = wr_timer_ctrl_reg && sfr_wdata_i[irq_ctrl_pkg::PEND_A_BIT];
    wire sw_set_b = wr_timer_ctrl_reg && sfr_wdata_i[irq_ctrl_pkg::PEND_B_BIT];
    wire clr_a = (wr_timer_ctrl_reg && !sfr_wdata_i[irq_ctrl_pkg::PEND_A_BIT]) || take_a;
    wire clr_b = (wr_timer_ctrl_reg && !sfr_wdata_i[irq_ctrl_pkg::PEND_B_BIT]) || take_b;
    wire set_a = ext_a_rise || sw_set_a;
    wire set_b = ext_b_rise || sw_set_b;

    // edge flags: set wins over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            edge_a_reg <= 1'b0;
            edge_b_reg <= 1'b0;
            act_a_prev_reg <= 1'b0;
            act_b_prev_reg <= 1'b0;
        end else begin
            edge_a_reg <= set_a || (edge_a_reg && !clr_a);
            edge_b_reg <= set_b || (edge_b_reg && !clr_b);
            act_a_prev_reg <= ext_a_active;
            act_b_prev_reg <= ext_b_active;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            en_main_reg <= irq_ctrl_pkg::RST_ZERO;
            en_ext1_reg <= irq_ctrl_pkg::RST_ZERO;
            en_ext2_reg <= irq_ctrl_pkg::RST_ZERO;
            pri_main_reg <= irq_ctrl_pkg::RST_ZERO;
            pri_ext1_reg <= irq_ctrl_pkg::RST_ZERO;
            pri_ext2_reg <= irq_ctrl_pkg::RST_ZERO;
            ext_cfg_reg <= irq_ctrl_pkg::RST_EXT_CONFIG;
            trig_a_reg <= 1'b0;
            trig_b_reg <= 1'b0;
        end else begin
            if (wr_en_main) en_main_reg <= sfr_wdata_i;
            if (wr_en_ext1) en_ext1_reg <= sfr_wdata_i;
            if (wr_en_ext2) en_ext2_reg <= sfr_wdata_i;
            if (wr_pri_main) pri_main_reg <= sfr_wdata_i;
            if (wr_pri_ext1) pri_ext1_reg <= sfr_wdata_i;
            if (wr_pri_ext2) pri_ext2_reg <= sfr_wdata_i;
            if (wr_cfg) ext_cfg_reg <= sfr_wdata_i;
            if (wr_timer_ctrl_reg) begin
                trig_a_reg <= sfr_wdata_i[irq_ctrl_pkg::TRIG_A_BIT];
                trig_b_reg <= sfr_wdata_i[irq_ctrl_pkg::TRIG_B_BIT];
            end
        end
    end

    // read mux, registered
    wire [7:0] timer_ctrl_reg_view = {4'h_0, ext_b_pending, trig_b_reg, ext_a_pending, trig_a_reg};
    wire [7:0] rd_next =
        (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_MAIN) ? en_main_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_EXT1) ? en_ext1_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_ENABLE_EXT2) ? en_ext2_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_MAIN) ? pri_main_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_EXT1) ? pri_ext1_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_PRIORITY_EXT2) ? pri_ext2_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_EXT_CONFIG) ? ext_cfg_reg :
        (sfr_addr_i == irq_ctrl_pkg::OFS_TIMER_CTRL) ? timer_ctrl_reg_view :
        irq_ctrl_pkg::RST_ZERO;

    always_ff @(posedge clk_i) begin
        if (reset_i) sfr_rdata_o <= irq_ctrl_pkg::RST_ZERO;
        else sfr_rdata_o <= rd_next;
    end

    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    // flat per-source vectors
    wire [N-1:0] pend_vec = {periph_pending_i[15:1], ext_b_pending, periph_pending_i[0], ext_a_pending};
    wire [N-1:0] en_vec = {en_ext2_reg[irq_ctrl_pkg::EXT2_SRC_BITS-1:0], en_ext1_reg,
                           en_main_reg[irq_ctrl_pkg::MAIN_SRC_BITS-1:0]};
    wire [N-1:0] pri_vec = {pri_ext2_reg[irq_ctrl_pkg::EXT2_SRC_BITS-1:0], pri_ext1_reg,
                            pri_main_reg[irq_ctrl_pkg::MAIN_SRC_BITS-1:0]};
    wire global_en = en_main_reg[irq_ctrl_pkg::GLOBAL_EN_BIT];
    wire [N-1:0] cand = pend_vec & en_vec & {N{global_en}};
    wire [N-1:0] hi_cand = cand & pri_vec;
    wire [N-1:0] lo_cand = cand & ~pri_vec;
    // high may interrupt low; nothing interrupts high
    wire hi_ok = |hi_cand && !in_hi_reg;
    wire lo_ok = |lo_cand && !in_hi_reg && !in_lo_reg;
    wire [4:0] win_idx = hi_ok ? lowest_idx(hi_cand) : lowest_idx(lo_cand);
    // recognise at an instruction boundary, not while stalled or just after return
    wire recog = (state_reg == irq_ctrl_pkg::ST_IDLE) && (hi_ok || lo_ok) && instr_done_i
                 && !cpu_stall_i && !hold_reg && !return_from_handler_i;

    // ----------------------------------------------------------------
    // call sequencer
    // ----------------------------------------------------------------
    assign long_subroutine_jump_o = (state_reg == irq_ctrl_pkg::ST_CALL);
    assign vector_taken_o = long_subroutine_jump_o && (cnt_reg == CALL_LAST) && !cpu_stall_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= irq_ctrl_pkg::ST_IDLE;
            cnt_reg <= 3'h_0;
            src_reg <= 5'h_00;
            src_hi_reg <= 1'b0;
            irq_vector_o <= 16'h_0000;
        end else begin
            case (state_reg)
                irq_ctrl_pkg::ST_IDLE: begin
                    if (recog) begin
                        state_reg <= irq_ctrl_pkg::ST_CALL;
                        cnt_reg <= 3'h_0;
                        src_reg <= win_idx;
                        src_hi_reg <= hi_ok;
                        irq_vector_o <= VEC_BASE + 16'(VEC_STRIDE * win_idx);
                    end
                end
                default: begin
                    if (!cpu_stall_i) begin
                        if (cnt_reg == CALL_LAST) state_reg <= irq_ctrl_pkg::ST_IDLE;
                        else cnt_reg <= cnt_reg + 3'h_1;
                    end
                end
            endcase
        end
    end
    assign irq_source_o = src_reg;

    // ----------------------------------------------------------------
    // active handler levels and post-return hold
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            in_hi_reg <= 1'b0;
            in_lo_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (vector_taken_o && src_hi_reg) in_hi_reg <= 1'b1;
            else if (return_from_handler_i && in_hi_reg) in_hi_reg <= 1'b0;
            if (vector_taken_o && !src_hi_reg) in_lo_reg <= 1'b1;
            else if (return_from_handler_i && !in_hi_reg) in_lo_reg <= 1'b0;
            // one more instruction must finish after the return
            if (return_from_handler_i) hold_reg <= 1'b1;
            else if (instr_done_i && !cpu_stall_i) hold_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_recog;
        recog;
    endsequence
    sequence s_call_run;
        (!cpu_stall_i) [*5];
    endsequence

    property p_min_response;
        @(posedge clk_i) disable iff (reset_i) s_recog ##1 s_call_run |-> vector_taken_o;
    endproperty
    a_min_response: assert property (p_min_response) else $error("call not done five cycles after detect");

    property p_stall_freeze;
        @(posedge clk_i) disable iff (reset_i) (long_subroutine_jump_o && cpu_stall_i) |=> long_subroutine_jump_o && $stable(cnt_reg);
    endproperty
    a_stall_freeze: assert property (p_stall_freeze) else $error("call advanced during stall");

    property p_no_preempt_hi;
        @(posedge clk_i) disable iff (reset_i) in_hi_reg |-> !recog;
    endproperty
    a_no_preempt_hi: assert property (p_no_preempt_hi) else $error("high handler preempted");

    property p_prio_reset;
        @(posedge clk_i) reset_i |=> (pri_vec == '0);
    endproperty
    a_prio_reset: assert property (p_prio_reset) else $error("priority not low after reset");

    property p_hold_after_return;
        @(posedge clk_i) disable iff (reset_i) return_from_handler_i |=> !recog;
    endproperty
    a_hold_after_return: assert property (p_hold_after_return) else $error("vectored right after return");

    // level flag against the raw pin two edges back, through the synchroniser
    property p_level_follow;
        @(posedge clk_i) disable iff (reset_i)
            !trig_a_reg |-> (timer_ctrl_reg_view[irq_ctrl_pkg::PEND_A_BIT]
                             == (pin_pick($past(port0_pins_i, 2), sel_a) ~^ pol_a));
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level flag differs from input");

    property p_level_follow_b;
        @(posedge clk_i) disable iff (reset_i)
            !trig_b_reg |-> (timer_ctrl_reg_view[irq_ctrl_pkg::PEND_B_BIT]
                             == (pin_pick($past(port0_pins_i, 2), sel_b) ~^ pol_b));
    endproperty
    a_level_follow_b: assert property (p_level_follow_b) else $error("level flag b differs from input");

    property p_edge_clear;
        @(posedge clk_i) disable iff (reset_i) (take_a && trig_a_reg && !set_a) |=> !edge_a_reg;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept after vector");

    property p_hi_first;
        @(posedge clk_i) disable iff (reset_i) (recog && |hi_cand) |-> pri_vec[win_idx];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("low serviced before high");

    // requests of the chosen level, and those of them below the winner
    wire [N-1:0] win_pool = hi_ok ? hi_cand : lo_cand;
    wire [N-1:0] below_win = win_pool & ((N'(1) << win_idx) - N'(1));

    property p_low_index;
        @(posedge clk_i) disable iff (reset_i) recog |-> win_pool[win_idx] && (below_win == '0);
    endproperty
    a_low_index: assert property (p_low_index) else $error("winner is not the lowest index");

    property p_win_latch;
        @(posedge clk_i) disable iff (reset_i) recog |=> long_subroutine_jump_o && (src_reg == $past(win_idx));
    endproperty
    a_win_latch: assert property (p_win_latch) else $error("winner not latched");

    property p_call_ends;
        @(posedge clk_i) disable iff (reset_i) vector_taken_o |=> !long_subroutine_jump_o;
    endproperty
    a_call_ends: assert property (p_call_ends) else $error("call still running after vector");

    property p_edge_clear_b;
        @(posedge clk_i) disable iff (reset_i) (take_b && trig_b_reg && !set_b) |=> !edge_b_reg;
    endproperty
    a_edge_clear_b: assert property (p_edge_clear_b) else $error("edge flag b kept after vector");
endmodule : ext_irq_priority_ctrl

// >>> testbench/cpu_seq_model.sv
// cpu sequencer model that vectors, stalls and returns from handlers
`timescale 1ns/1ps
module cpu_seq_model #(
    parameter int HANDLER_LEN = 20
) (
    input wire logic clk_i, // system clock
    input wire logic reset_i, // synchronous reset
    input wire logic jump_i, // call in progress
    input wire logic taken_i, // cpu enters handler
    input wire logic [3:0] stall_len_i, // stall cycles per call
    output logic instr_done_o, // instruction boundary
    output logic return_o, // handler return pulse
    output logic cpu_stall_o // cpu stalled
);
    int depth;
    int left [0:2];
    logic [3:0] st_cnt;
    // -------------------------------------------------------------
    // one instruction a cycle outside calls and stalls
    // -------------------------------------------------------------
    assign instr_done_o = !jump_i && !cpu_stall_o;
    assign return_o = instr_done_o && depth > 0 && left[depth] == 1;
    // stall inside each call, then count handler instructions down
    always @(posedge clk_i) begin
        if (reset_i) begin
            depth <= 0;
            st_cnt <= 4'h_0;
            cpu_stall_o <= 1'b0;
        end else begin
            cpu_stall_o <= jump_i && st_cnt < stall_len_i;
            if (!jump_i) st_cnt <= 4'h_0;
            else if (st_cnt < stall_len_i) st_cnt <= st_cnt + 4'h_1;
            if (taken_i) begin
                depth <= depth + 1;
                left[depth + 1] <= HANDLER_LEN;
            end else if (return_o) depth <= depth - 1;
            else if (instr_done_o && depth > 0) left[depth] <= left[depth] - 1;
        end
    end
endmodule : cpu_seq_model

// >>> testbench/ext_irq_priority_ctrl_tb.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    num_checks++; \
    if ((got) !== (ex)) begin \
        $display("wrong value %s expected %h seen %h", nm, ex, got); \
        n_mismatch++; \
    end
module ext_irq_priority_ctrl_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr = 8'h_00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h_00;
    logic [15:0] periph = 16'h_0000;
    logic [7:0] pins = 8'h_ff;
    logic [3:0] stall_len = 4'h_0;
    logic [7:0] rdata;
    logic [15:0] vec;
    logic [4:0] src;
    logic jump, taken, done, ret, stall;
    int n_mismatch = 0;
    int num_checks = 0;
    localparam logic [7:0] OFS [0:8] = '{irq_ctrl_pkg::OFS_ENABLE_MAIN, irq_ctrl_pkg::OFS_PRIORITY_MAIN,
        irq_ctrl_pkg::OFS_EXT_CONFIG, irq_ctrl_pkg::OFS_ENABLE_EXT1, irq_ctrl_pkg::OFS_ENABLE_EXT2,
        irq_ctrl_pkg::OFS_PRIORITY_EXT1, irq_ctrl_pkg::OFS_PRIORITY_EXT2, irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_90};
    // -------------------------------------------------------------
    // clock, design and cpu model
    // -------------------------------------------------------------
    always #20 clk_i = ~clk_i;
    ext_irq_priority_ctrl i_dut (.clk_i(clk_i), .reset_i(reset_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .periph_pending_i(periph), .port0_pins_i(pins),
        .instr_done_i(done), .return_from_handler_i(ret), .cpu_stall_i(stall),
        .long_subroutine_jump_o(jump), .irq_vector_o(vec), .irq_source_o(src), .vector_taken_o(taken));
    cpu_seq_model i_cpu (.clk_i(clk_i), .reset_i(reset_i), .jump_i(jump), .taken_i(taken),
        .stall_len_i(stall_len), .instr_done_o(done), .return_o(ret), .cpu_stall_o(stall));
    // peripherals drop their flag when the cpu vectors to them
    always @(posedge clk_i) begin
        if (taken === 1'b1 && src > 5'h_02) periph <= periph & ~(16'h_0001 << (src - 5'h_02));
        else if (taken === 1'b1 && src === 5'h_01) periph <= periph & 16'h_fffe;
    end
    // -------------------------------------------------------------
    // shared tasks
    // -------------------------------------------------------------
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr <= a;
        wr <= 1'b1;
        wdata <= d;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_i);
        addr <= a;
        tick;
        `CHK(nm, ex, rdata)
    endtask : chk_reg
    // waits for a call, then checks its source, vector and length
    task automatic run_call(input logic [4:0] s, input int len);
        int k;
        int vt;
        k = 0;
        vt = 0;
        while (jump !== 1'b1 && k < 200) begin
            tick;
            k++;
        end
        `CHK("irq_source", s, src)
        `CHK("irq_vector", irq_ctrl_pkg::VEC_BASE + irq_ctrl_pkg::VEC_STRIDE * 16'(s), vec)
        k = 0;
        while (jump === 1'b1 && k < 50) begin
            if (taken === 1'b1) vt = k + 1;
            tick;
            k++;
        end
        `CHK("call_cycles", len, k)
        `CHK("taken_cycle", len, vt)
    endtask : run_call
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 9; i++) begin
            chk_reg("reset_reg", OFS[i], (i == 2) ? 8'h_01 : 8'h_00);
        end
        `CHK("jump_idle", 1'b0, jump)
    endtask : t_reset
    task automatic t_edge;
        wr_reg(irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_03);
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_81);
        run_call(5'h_00, 5);
        chk_reg("pending_a", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_01);
        repeat (40) tick;
        @(posedge clk_i);
        stall_len <= 4'h_3;
        wr_reg(irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_03);
        run_call(5'h_00, 8);
        @(posedge clk_i);
        stall_len <= 4'h_0;
        repeat (40) tick;
    endtask : t_edge
    task automatic t_level;
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_00);
        @(posedge clk_i);
        pins <= 8'h_df;
        wr_reg(irq_ctrl_pkg::OFS_EXT_CONFIG, 8'h_d1);
        chk_reg("ext_config", irq_ctrl_pkg::OFS_EXT_CONFIG, 8'h_d1);
        chk_reg("pending_b_off", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_01);
        @(posedge clk_i);
        pins <= 8'h_ff;
        repeat (3) tick;
        chk_reg("pending_b_on", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_09);
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_84);
        run_call(5'h_02, 5);
        @(posedge clk_i);
        pins <= 8'h_df;
        repeat (3) tick;
        chk_reg("pending_b_gone", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_01);
        repeat (40) tick;
        // both inputs edge mode, both active high; pulse on pin 5 must latch
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_80);
        wr_reg(irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_05);
        wr_reg(irq_ctrl_pkg::OFS_EXT_CONFIG, 8'h_d9);
        @(posedge clk_i);
        pins <= 8'h_ff;
        @(posedge clk_i);
        pins <= 8'h_df;
        repeat (3) tick;
        chk_reg("edge_latch", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_0f);
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_84);
        run_call(5'h_02, 5);
        chk_reg("edge_b_cleared", irq_ctrl_pkg::OFS_TIMER_CTRL, 8'h_07);
        repeat (40) tick;
    endtask : t_level
    task automatic t_prio;
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_80);
        @(posedge clk_i);
        periph <= 16'h_0003;
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_MAIN, 8'h_8a);
        run_call(5'h_01, 5);
        run_call(5'h_03, 5);
        repeat (40) tick;
        wr_reg(irq_ctrl_pkg::OFS_PRIORITY_EXT1, 8'h_80);
        wr_reg(irq_ctrl_pkg::OFS_ENABLE_EXT1, 8'h_80);
        chk_reg("prio_ext1", irq_ctrl_pkg::OFS_PRIORITY_EXT1, 8'h_80);
        @(posedge clk_i);
        periph <= 16'h_0001;
        run_call(5'h_01, 5);
        @(posedge clk_i);
        periph <= periph | 16'h_0800;
        run_call(5'h_0d, 5);
        `CHK("nest_depth", 2, i_cpu.depth)
        repeat (60) tick;
    endtask : t_prio
    // -------------------------------------------------------------
    // verdict, watchdog and main sequence
    // -------------------------------------------------------------
    task automatic test_done;
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // under 500 cycles are needed; allow 10000 cycles of 40 ns, over twenty times that
    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        tick;
        t_reset;
        t_edge;
        t_level;
        t_prio;
        test_done;
    end
endmodule : ext_irq_priority_ctrl_tb
